// [cid_channel_input.sv]
// channel input stage: float split, demux capture, update enables
// Contract
// - floating format splits word mantissa/exponent
// - mantissa size code picks split point
// - delay code waits 0..7 clocks
// - pick one of eight multiplexed streams
// - delayed samples realigned to next strobe
// - gated mode advances both on strobe
// - interpolated mode integrator every clock
// - oscillator advances only on strobe
module cid_channel_input
    import cid_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [15:0] sample_data,
    input  wire logic        sample_qualify_strobe,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [13:0]      mixer_mant,
    output logic [2:0]       mixer_exp,
    output logic             mixer_valid,
    output logic             carrier_oscillator_advance,
    output logic             integrate_comb_decimator_advance
);
    typedef struct packed {
        logic [15:0] din_s1;
        logic [15:0] din_s2;
        logic        stb_s1;
        logic        stb_s2;
        logic [31:0] ctrl;
        logic        armed;
        logic [2:0]  cnt;
        logic        held_ok;
        cid_word_t   held;
        cid_word_t   out;
        logic        out_vld;
        logic        osc_adv;
        logic        dec_adv;
        logic [15:0] cap_count;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  aw_ofs;
        logic        aw_bad;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cid_state_t;

    cid_state_t s_q;
    cid_state_t s_d;
    cid_cfg_t    cfg;
    cid_word_t   split_w;
    logic [31:0] merged_w;

    // control fields pulled from the control word
    assign cfg.float_en  = s_q.ctrl[CID_FLOAT_BIT];
    assign cfg.mant_size = s_q.ctrl[CID_MSIZE_LO +: 2];
    assign cfg.delay     = s_q.ctrl[CID_DELAY_LO +: 3];
    assign cfg.interp    = s_q.ctrl[CID_MODE_BIT];

    // the delay field must reach the last stream slot of a frame
    localparam int STREAMS = 8;
    if ((1 << $bits(cfg.delay)) < STREAMS) begin : g_delay_check
        $error("delay field too narrow for the stream count");
    end

    // byte lanes with a strobe take new data, the rest keep old bits
    // done from registered copies so the merge never sees bus glitches
    for (genvar gi = 0; gi < 4; gi++) begin : g_lane
        assign merged_w[gi*8 +: 8] = s_q.wstrb[gi] ? s_q.wdata[gi*8 +: 8]
                                                  : s_q.ctrl[gi*8 +: 8];
    end

    // float split of the synced word
    cid_split u_split (
        .din       (s_q.din_s2),
        .float_en  (cfg.float_en),
        .mant_size (cfg.mant_size),
        .word      (split_w)
    );

    // ready terms are combinational handshakes
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign mixer_mant    = s_q.out.mant;
    assign mixer_exp     = s_q.out.expo;
    assign mixer_valid   = s_q.out_vld;
    assign carrier_oscillator_advance       = s_q.osc_adv;
    assign integrate_comb_decimator_advance = s_q.dec_adv;

    // next state of the whole stage
    always_comb begin
        logic strobe;
        strobe = s_q.stb_s2;
        s_d = s_q;
        // pins pass two flops before use
        s_d.din_s1 = sample_data;
        s_d.din_s2 = s_q.din_s1;
        s_d.stb_s1 = sample_qualify_strobe;
        s_d.stb_s2 = s_q.stb_s1;

        // a new strobe restarts the count
        if (strobe) begin
            s_d.armed = 1'b1;
            s_d.cnt   = 3'h0;
        end else if (s_q.armed) begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
        if (strobe && cfg.delay == 3'h0) begin
            s_d.held    = split_w;
            s_d.held_ok = 1'b1;
            s_d.armed   = 1'b0;
        end else if (!strobe && s_q.armed
                     && s_q.cnt + 3'h1 == cfg.delay) begin
            s_d.held    = split_w;
            s_d.held_ok = 1'b1;
            s_d.armed   = 1'b0;
            s_d.cap_count = s_q.cap_count + 16'h0001;
        end
        if (strobe && cfg.delay == 3'h0) begin
            s_d.cap_count = s_q.cap_count + 16'h0001;
        end
        // release held sample at next strobe
        // costs one frame latency even at zero delay
        s_d.out_vld = strobe && s_q.held_ok;
        if (strobe && s_q.held_ok) begin
            s_d.out = s_q.held;
        end
        s_d.osc_adv = strobe;
        // integrator free runs only when interpolated
        s_d.dec_adv = cfg.interp || strobe;

        // axi write address and data, either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.aw_ofs = s_axi_awaddr[3:0];
            // upper bits set would alias onto the control word
            s_d.aw_bad = |s_axi_awaddr[31:4];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end
        // both halves held: commit and answer on the following edge
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            if (s_q.aw_ofs == CID_CTRL_OFS && !s_q.aw_bad) begin
                s_d.ctrl  = merged_w & CID_CTRL_MASK;
                s_d.bresp = CID_RESP_OK;
            end else begin
                s_d.bresp = CID_RESP_ERR;
            end
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // axi read: one cycle after address
        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = CID_RESP_OK;
            case (s_axi_araddr[3:0])
                CID_CTRL_OFS: s_d.rdata = s_q.ctrl;
                CID_MANT_OFS: s_d.rdata = {18'h0, s_q.out.mant};
                CID_EXP_OFS:  s_d.rdata = {29'h0, s_q.out.expo};
                CID_STAT_OFS: s_d.rdata = {16'h0, s_q.cap_count};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = CID_RESP_ERR;
                end
            endcase
            // only the low sixteen bytes are mapped, the rest refuse
            if (|s_axi_araddr[31:4]) begin
                s_d.rdata = 32'h0000_0000;
                s_d.rresp = CID_RESP_ERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // one register holds all state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q      <= '0;
            s_q.ctrl <= CID_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // cid_channel_input

// [cid_pkg.sv]
// package for the channel input format and demux stage
package cid_pkg;
    // register byte offsets
    localparam logic [3:0] CID_CTRL_OFS    = 4'h0;
    localparam logic [3:0] CID_MANT_OFS    = 4'h4;
    localparam logic [3:0] CID_EXP_OFS     = 4'h8;
    localparam logic [3:0] CID_STAT_OFS    = 4'hC;
    // control field positions
    localparam int CID_FLOAT_BIT   = 9;
    localparam int CID_MSIZE_LO    = 7;
    localparam int CID_DELAY_LO    = 4;
    localparam int CID_MODE_BIT    = 3;
    localparam logic [31:0] CID_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CID_CTRL_MASK = 32'h0000_03F8;
    // mantissa size codes
    localparam logic [1:0] CID_MS_11_3 = 2'h0;
    localparam logic [1:0] CID_MS_12_3 = 2'h1;
    localparam logic [1:0] CID_MS_13_3 = 2'h2;
    localparam logic [1:0] CID_MS_14_2 = 2'h3;
    // axi answers
    localparam logic [1:0] CID_RESP_OK  = 2'h0;
    localparam logic [1:0] CID_RESP_ERR = 2'h2;

    // configuration carried to the datapath
    typedef struct packed {
        logic       float_en;
        logic [1:0] mant_size;
        logic [2:0] delay;
        logic       interp;
    } cid_cfg_t;

    // one split input word
    typedef struct packed {
        logic [13:0] mant;
        logic [2:0]  expo;
    } cid_word_t;
endpackage

// [cid_properties.sv]
// port checker for the channel input stage
module cid_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        sample_qualify_strobe,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [13:0] mixer_mant,
    input wire logic [2:0]  mixer_exp,
    input wire logic        mixer_valid,
    input wire logic        carrier_oscillator_advance,
    input wire logic        integrate_comb_decimator_advance
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // sync latency allows two or three clocks
    chk_osc_cause: assert property (
        carrier_oscillator_advance |-> $past(sample_qualify_strobe, 2)
        || $past(sample_qualify_strobe, 3)) else $error("osc step no strobe");
    chk_dec_with_osc: assert property (
        carrier_oscillator_advance |-> integrate_comb_decimator_advance)
        else $error("decimator missed a strobe step");
    chk_valid_aligned: assert property (
        mixer_valid |-> carrier_oscillator_advance)
        else $error("sample not aligned to strobe");
    chk_mant_held: assert property (
        $changed(mixer_mant) |-> mixer_valid) else $error("mantissa moved");
    chk_exp_held: assert property (
        $changed(mixer_exp) |-> mixer_valid) else $error("exponent moved");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    chk_b_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("no read answer");
    cov_sample: cover property (mixer_valid);
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // cid_props
bind cid_channel_input cid_props i_cid_props (.*);

// [cid_split.sv]
// splits a 16-bit floating input word into mantissa and exponent
module cid_split
    import cid_pkg::*;
(
    input  wire logic [15:0] din,
    input  wire logic        float_en,
    input  wire logic [1:0]  mant_size,
    output cid_word_t        word
);
    always_comb begin
        word = '0;
        if (!float_en) begin
            word.mant = din[15:2];   // fixed point: top bits pass
        end else begin
            case (mant_size)
                CID_MS_11_3: begin
                    word.mant = {3'h0, din[15:5]};
                    word.expo = din[2:0];
                end
                CID_MS_12_3: begin
                    word.mant = {2'h0, din[15:4]};
                    word.expo = din[2:0];
                end
                CID_MS_13_3: begin
                    word.mant = {1'h0, din[15:3]};
                    word.expo = din[2:0];
                end
                default: begin
                    word.mant = din[15:2];
                    word.expo = {1'h0, din[1:0]};
                end
            endcase
        end
    end
endmodule // cid_split

// [cid_src_model.sv]
// sample source: eight-slot frames, strobe on slot zero
module cid_src_model (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [15:0] base,
    output logic [15:0]      data,
    output logic             strobe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] slot_q = 3'h0;
    initial {data, strobe} = 17'h0;
    // one-clock strobe; idle bus toggles so stale data never matches
    always @(posedge clk) begin
        slot_q <= run ? slot_q + 3'h1 : 3'h0;
        strobe <= run && slot_q == 3'h0;
        data   <= run ? base + 16'(slot_q) : ~data;
    end
endmodule // cid_src_model

// [tb_channel_input_format_demux.sv]
// self-checking bench for the channel input stage
module tb_channel_input_format_demux import cid_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'h0, rstn = 1'h0, run = 1'h0;
    logic [15:0] base = 16'h0, sample_data;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [13:0] mixer_mant, m;
    logic [2:0]  mixer_exp, e;
    logic        mixer_valid, carrier_oscillator_advance;
    logic        integrate_comb_decimator_advance, sample_qualify_strobe;
    logic [31:0] d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    int          fail_count = 0, n_compared = 0;
    cid_channel_input i_cid_channel_input (.*);
    cid_src_model i_cid_src_model (.clk(clk), .run(run), .base(base),
        .data(sample_data), .strobe(sample_qualify_strobe));
    // 40 MHz clock
    always #12.5 clk = ~clk;
    task automatic check(input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // aw and w may be taken on different edges
    task automatic axw(input logic [31:0] a, v);
        logic pa, pw, ta, tw;
        {pa, pw} = 2'h3;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        s_axi_bready <= 1'h1;
        do @(negedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(negedge clk); while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        @(posedge clk);
        s_axi_rready <= 1'h0;
    endtask
    // third aligned sample, so the new setting has surely settled
    task automatic sample3(input logic [15:0] b);
        base <= b;
        run <= 1'h1;
        repeat (3) do @(negedge clk); while (!mixer_valid);
        {m, e} = {mixer_mant, mixer_exp};
        @(posedge clk);
    endtask
    task automatic regs;
        axr(CID_CTRL_OFS);
        check(d, CID_CTRL_RST);
        axw(CID_CTRL_OFS, 32'hFFFF_FFFF);
        check(r, CID_RESP_OK);
        axr(CID_CTRL_OFS);
        check(d, CID_CTRL_MASK);
        // lane zero alone clears only the low control bits
        s_axi_wstrb <= 4'h1;
        axw(CID_CTRL_OFS, 32'h0);
        s_axi_wstrb <= 4'hF;
        axr(CID_CTRL_OFS);
        check(d, CID_CTRL_MASK & 32'hFFFF_FF00);
        axw(CID_STAT_OFS, 32'h1);
        check(r, CID_RESP_ERR);
        axr(32'h10);
        check(d, 32'h0);
        check(r, CID_RESP_ERR);
        $display("registers done");
    endtask
    task automatic split_test;
        for (int c = 0; c < 4; c++) begin
            axw(CID_CTRL_OFS,
                32'h1 << CID_FLOAT_BIT | 32'(c) << CID_MSIZE_LO);
            sample3(16'hB6D9 ^ 16'(c));
            check(m, (16'hB6D9 ^ 16'(c)) >> (5 - c));
            check(e, c == 3 ? 3'(c & 3) ^ 3'h1 : 3'h1 ^ 3'(c));
            axr(CID_MANT_OFS);
            check(d, (16'hB6D9 ^ 16'(c)) >> (5 - c));
            axr(CID_EXP_OFS);
            check(d, c == 3 ? 3'(c & 3) ^ 3'h1 : 3'h1 ^ 3'(c));
        end
        $display("split done");
    endtask
    task automatic delay_test;
        for (int k = 0; k < 8; k++) begin
            axw(CID_CTRL_OFS, 32'(k) << CID_DELAY_LO);
            sample3(16'h4A30 ^ 16'(k << 8));
            check(m, (16'h4A30 ^ 16'(k << 8)) + 16'(k) >> 2);
            check(e, 3'h0);
            axr(CID_EXP_OFS);
            check(d, 32'h0);
        end
        $display("delay done");
    endtask
    task automatic modes;
        int nd, no;
        for (int k = 0; k < 2; k++) begin
            axw(CID_CTRL_OFS, 32'(k) << CID_MODE_BIT);
            repeat (16) @(negedge clk);
            {nd, no} = 0;
            repeat (16) begin
                @(negedge clk);
                nd += integrate_comb_decimator_advance;
                no += carrier_oscillator_advance;
            end
            // next write must start just after a rising edge
            @(posedge clk);
            check(no, 2);
            check(nd, k ? 16 : 2);
        end
        $display("modes done");
    endtask
    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog far beyond the expected run length
    initial begin
        #100us;
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        regs();
        split_test();
        delay_test();
        modes();
        complete_run();
    end
endmodule // tb_channel_input_format_demux
